// ==== rtl/dls_pkg.sv ====
package dls_pkg;
  localparam int DLS_CODE_W     = 12;
  localparam int DLS_BYTE_W     = 8;
  localparam int DLS_EN_BIT     = 7;
  localparam int DLS_MODE_HI    = 4;
  localparam int DLS_MODE_LO    = 3;
  localparam int DLS_JUST_HI    = 2;
  localparam int DLS_JUST_LO    = 0;
  localparam logic [7:0]  DLS_CTRL_RESET = 8'h00;
  localparam logic [7:0]  DLS_CTRL_MASK  = 8'h9F;
  localparam logic [7:0]  DLS_DATA_RESET = 8'h00;
  localparam logic [11:0] DLS_CODE_RESET = 12'h000;

  typedef enum logic [1:0] {
    DLS_UPD_HIGH_WRITE,
    DLS_UPD_TIMER3,
    DLS_UPD_TIMER4,
    DLS_UPD_TIMER2
  } dls_update_e;

  typedef struct packed {
    logic       wr_ctrl;
    logic       wr_high;
    logic       wr_low;
    logic [7:0] wdata;
  } dls_wr_s;

  typedef struct packed {
    logic        enable;
    logic [11:0] code;
  } dls_out_s;
endpackage : dls_pkg

// ==== rtl/dls_scheduler.sv ====
`timescale 1ns/100ps
`default_nettype none
// What this block does
// [RULE1] each channel outputs a 12-bit unsigned code, 000 to fff
// [RULE2] clearing enable tristates output and powers down the converter
// [RULE3] update source 00 at bits 4:3 loads latch on high-byte write
// [RULE4] low-byte writes are only staged until the high byte is written
// [RULE5] software writes low byte first, then high byte for 12 bits
// [RULE6] for 8-bit use, software preloads low byte and writes only high
// [RULE7] update source 01, 10, 11 wait for timer 3, 4 or 2 overflow
// [RULE8] selected overflow copies high and low together in one load
// [RULE9] justification field at bits 2:0 selects one of five placements
// [RULE10] second channel with own registers behaves identically
// [RULE11] software sets shared analog bias enable before using channels
// [RULE12] codes 000-100 put top 4..8 bits in high byte, rest left-aligned
// [RULE13] control resets to zero: disabled, high-write update, 4-bit justify
module dls_scheduler (
  // clock and reset
  input  wire logic           ref_clk,
  input  wire logic           rst,
  input  wire logic           clk_en,
  // register writes per channel
  input  wire dls_pkg::dls_wr_s wr_a,
  input  wire dls_pkg::dls_wr_s wr_b,
  // timer overflow pulses
  input  wire logic           timer2_ovf,
  input  wire logic           timer3_ovf,
  input  wire logic           timer4_ovf,
  // register readback
  output logic [7:0]          converter_a_control,
  output logic [7:0]          converter_a_data_high,
  output logic [7:0]          converter_a_data_low,
  output logic [7:0]          converter_b_control,
  output logic [7:0]          converter_b_data_high,
  output logic [7:0]          converter_b_data_low,
  // converter latches
  output dls_pkg::dls_out_s   converter_a,
  output dls_pkg::dls_out_s   converter_b
);
  import dls_pkg::*;

  localparam int NCH = 2;
  localparam int BW  = DLS_BYTE_W;
  localparam int CW  = DLS_CODE_W;

  // [RULE10] two identical channels share one generate body
  dls_wr_s       wr     [NCH];
  logic [BW-1:0] ctrl   [NCH];
  logic [BW-1:0] hi     [NCH];
  logic [BW-1:0] lo     [NCH];
  logic          pend   [NCH];
  logic          en_q   [NCH];
  logic [CW-1:0] code_q [NCH];

  assign wr[0] = wr_a;
  assign wr[1] = wr_b;

  for (genvar c = 0; c < NCH; c++) begin : g_ch

    // field decode
    logic [1:0]    mode_f;
    dls_update_e   upd;
    logic [2:0]    just;
    logic          sel_j0;
    logic          sel_j1;
    logic          sel_j2;
    logic          sel_j3;
    logic          sel_j4;
    logic          sel_t2;
    logic          sel_t3;
    logic          sel_t4;
    logic          on_high;

    // justified candidates
    logic [CW-1:0] word_j0;
    logic [CW-1:0] word_j1;
    logic [CW-1:0] word_j2;
    logic [CW-1:0] word_j3;
    logic [CW-1:0] word_j4;
    logic [CW-1:0] word;

    // strobes and next values
    logic          ctrl_we;
    logic          hi_we;
    logic          lo_we;
    logic          ovf_sel;
    logic          load;
    logic [BW-1:0] next_ctrl;
    logic [BW-1:0] next_hi;
    logic [BW-1:0] next_lo;
    logic          next_pend;
    logic          next_en;
    logic [CW-1:0] next_code;

    // decode stays combinational; only the registers below hold state
    // strobes count only while the clock enable runs
    assign ctrl_we = clk_en && wr[c].wr_ctrl;
    assign hi_we   = clk_en && wr[c].wr_high;
    assign lo_we   = clk_en && wr[c].wr_low;

    // [RULE9] justify field at bits 2:0
    assign just   = ctrl[c][DLS_JUST_HI:DLS_JUST_LO];
    // [RULE3] update source at bits 4:3
    assign mode_f = ctrl[c][DLS_MODE_HI:DLS_MODE_LO];
    assign upd    = dls_update_e'(mode_f);

    // [RULE12] one-hot placement decode
    assign sel_j0 = (just == 3'h0);
    assign sel_j1 = (just == 3'h1);
    assign sel_j2 = (just == 3'h2);
    assign sel_j3 = (just == 3'h3);
    // codes 101-111 are unused; the widest form keeps them harmless
    assign sel_j4 = (just >= 3'h4);

    // [RULE12] top 4..8 bits sit in the high byte
    assign word_j0 = {hi[c][3:0], lo[c][7:0]};
    assign word_j1 = {hi[c][4:0], lo[c][7:1]};
    assign word_j2 = {hi[c][5:0], lo[c][7:2]};
    assign word_j3 = {hi[c][6:0], lo[c][7:3]};
    assign word_j4 = {hi[c][7:0], lo[c][7:4]};

    // [RULE1] and-or pick keeps one 12-bit path
    assign word = ({CW{sel_j0}} & word_j0) |
                  ({CW{sel_j1}} & word_j1) |
                  ({CW{sel_j2}} & word_j2) |
                  ({CW{sel_j3}} & word_j3) |
                  ({CW{sel_j4}} & word_j4);

    // [RULE7] only the selected timer counts
    assign sel_t3  = (upd == DLS_UPD_TIMER3);
    assign sel_t4  = (upd == DLS_UPD_TIMER4);
    assign sel_t2  = (upd == DLS_UPD_TIMER2);
    assign on_high = (upd == DLS_UPD_HIGH_WRITE);
    assign ovf_sel = (sel_t3 && timer3_ovf) ||
                     (sel_t4 && timer4_ovf) ||
                     (sel_t2 && timer2_ovf);

    // [RULE3] arm a load for the edge after the high byte lands
    // hazard: a high write in a timer mode waits for the next overflow
    assign next_pend = on_high && wr[c].wr_high;
    // [RULE8] one load moves both bytes at once
    assign load      = ovf_sel || pend[c];
    assign next_ctrl = wr[c].wdata & DLS_CTRL_MASK;
    assign next_hi   = wr[c].wdata;
    assign next_lo   = wr[c].wdata;
    // [RULE2] enable follows the control bit
    assign next_en   = ctrl[c][DLS_EN_BIT];
    assign next_code = word;

    // [RULE13] control zero after reset
    // bits 6:5 always read back as zero
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        ctrl[c] <= DLS_CTRL_RESET;
      end else if (ctrl_we) begin
        ctrl[c] <= next_ctrl;
      end
    end

    // [RULE3] high byte staging
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        hi[c] <= DLS_DATA_RESET;
      end else if (hi_we) begin
        hi[c] <= next_hi;
      end
    end

    // [RULE4] low byte is staged only, never loads
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        lo[c] <= DLS_DATA_RESET;
      end else if (lo_we) begin
        lo[c] <= next_lo;
      end
    end

    // clk_en low holds every register, pending load included
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        pend[c] <= 1'b0;
      end else if (clk_en) begin
        pend[c] <= next_pend;
      end
    end

    // [RULE2] enable register
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        en_q[c] <= 1'b0;
      end else if (clk_en) begin
        en_q[c] <= next_en;
      end
    end

    // [RULE8] input latch, timer loads use bytes staged before the edge
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        code_q[c] <= DLS_CODE_RESET;
      end else if (clk_en && load) begin
        code_q[c] <= next_code;
      end
    end
  end

  // output pins come straight from flops
  // channel a readback and latch
  assign converter_a_control   = ctrl[0];
  assign converter_a_data_high = hi[0];
  assign converter_a_data_low  = lo[0];
  assign converter_a           = '{enable: en_q[0], code: code_q[0]};

  // channel b readback and latch
  assign converter_b_control   = ctrl[1];
  assign converter_b_data_high = hi[1];
  assign converter_b_data_low  = lo[1];
  assign converter_b           = '{enable: en_q[1], code: code_q[1]};
endmodule : dls_scheduler
`default_nettype wire

// ==== bench/dls_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
module dls_chk (
  // watched ports, channel a only
  input wire logic ref_clk, rst, clk_en, timer2_ovf, timer3_ovf, timer4_ovf,
  input wire dls_pkg::dls_wr_s wr_a,
  input wire logic [7:0] converter_a_control, converter_a_data_high,
  input wire logic [7:0] converter_a_data_low,
  input wire dls_pkg::dls_out_s converter_a
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire [1:0] md = converter_a_control[4:3];
  wire sel = md == 1 && timer3_ovf || md == 2 && timer4_ovf ||
    md == 3 && timer2_ovf;
  wire hw = clk_en && wr_a.wr_high;
  // codes above 100 place as 100
  wire [11:0] jw = 12'({converter_a_data_high, converter_a_data_low} >>
    (converter_a_control[2:0] > 4 ? 3'd4 : converter_a_control[2:0]));
  AST_RST: assert property ($fell(rst) |-> converter_a == '0)
    else $error("latch not clear after reset");
  AST_CRB: assert property (clk_en && wr_a.wr_ctrl |=>
    converter_a_control == ($past(wr_a.wdata) & 8'h9F)) else $error("ctrl");
  AST_EN: assert property (clk_en |=>
    converter_a.enable == $past(converter_a_control[7])) else $error("en");
  AST_HRB: assert property (hw |=>
    converter_a_data_high == $past(wr_a.wdata)) else $error("high byte");
  AST_LOW: assert property (clk_en && wr_a.wr_low && md == 0 && !hw &&
    !$past(hw) |=> converter_a_data_low == $past(wr_a.wdata) &&
    $stable(converter_a.code)) else $error("low write loaded");
  AST_THOLD: assert property (clk_en && md != 0 && !sel && !hw &&
    !$past(hw) |=> $stable(converter_a.code)) else $error("early load");
  AST_TLOAD: assert property (clk_en && md != 0 && sel |=>
    converter_a.code == $past(jw)) else $error("timer load");
  AST_HW: assert property (hw && md == 0 && clk_en |-> ##2
    converter_a.code == jw) else $error("high write load");
  AST_FRZ: assert property (!clk_en |=> $stable(converter_a) &&
    $stable(converter_a_control) && $stable(converter_a_data_high) &&
    $stable(converter_a_data_low)) else $error("state moved while frozen");
endmodule : dls_chk
`default_nettype wire

// ==== bench/dls_scheduler_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module dls_scheduler_tb_top;
  import dls_pkg::*;
  logic ref_clk = 0, rst = 1, clk_en = 1;
  logic [3:1] tovf = '0;
  dls_wr_s wa = '0, wb = '0;
  dls_out_s oa, ob;
  logic [7:0] ac, ah, al, bc, bh, bl;
  logic [11:0] pv;
  int err_count = 0, check_count = 0, cyc = 0;
  dls_scheduler dut_u (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
    .wr_a(wa), .wr_b(wb), .timer2_ovf(tovf[3]), .timer3_ovf(tovf[1]),
    .timer4_ovf(tovf[2]), .converter_a_control(ac),
    .converter_a_data_high(ah), .converter_a_data_low(al),
    .converter_b_control(bc), .converter_b_data_high(bh),
    .converter_b_data_low(bl), .converter_a(oa), .converter_b(ob));
  initial forever #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (++cyc > 3000) begin
    err_count++;
    summarize();
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(logic [63:0] got, exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one strobe, then a quiet edge so strobes never merge
  task automatic wr(bit ch, logic [2:0] k, logic [7:0] d);
    if (ch) wb <= {k, d}; else wa <= {k, d};
    @(posedge ref_clk) #1 wa <= '0;
    wb <= '0;
    @(posedge ref_clk) #1;
  endtask : wr
  task automatic ld(bit ch, logic [7:0] c, l, h);
    wr(ch, 3'b100, c);
    wr(ch, 3'b001, l);
    wr(ch, 3'b010, h);
    repeat (3) @(posedge ref_clk) #1;
  endtask : ld
  task automatic tick(logic [3:1] t);
    tovf <= t;
    @(posedge ref_clk) #1 tovf <= '0;
  endtask : tick
  initial begin
    repeat (2) @(posedge ref_clk) #1;
    // bias enable sits outside this block and is taken as set
    rst = 0;
    chk({oa, ob, ac, bc}, '0);
    for (int j = 0; j < 8; j++) if (j < 5 || j == 7) begin
      ld(0, 8'(j) | 8'h80, 8'hA5, 8'h3C);
      chk({oa, ac, ah}, {1'b1, 12'(16'h3CA5 >> (j > 4 ? 4 : j)),
        8'(j) | 8'h80, 8'h3C});
    end
    wr(0, 3'b001, 8'h00);
    repeat (3) @(posedge ref_clk) #1;
    chk({oa.code, al}, {12'h3CA, 8'h00});
    wr(0, 3'b010, 8'h5A);
    repeat (3) @(posedge ref_clk) #1;
    chk({oa.code, ah}, {12'h5A0, 8'h5A});
    $display("justify and staging done");
    pv = 12'h5A0;
    for (int m = 1; m < 4; m++) begin
      ld(0, 8'(m << 3) | 8'h82, 8'hC0, 8'(m * 17));
      tick(~3'(1 << (m - 1)));
      chk(oa.code, pv);
      tick(3'(1 << (m - 1)));
      pv = 12'({8'(m * 17), 8'hC0} >> 2);
      chk(oa.code, pv);
    end
    clk_en <= 0;
    wr(0, 3'b010, 8'hFF);
    tick(3'b100);
    chk({oa.code, ah}, {pv, 8'h33});
    clk_en <= 1;
    tick(3'b100);
    chk(oa.code, 12'hCF0);
    $display("timer scheduling and freeze done");
    ld(1, 8'h82, 8'hF0, 8'h2B);
    chk({ob, bc, bh, bl, oa.code},
      {1'b1, 12'hAFC, 8'h82, 8'h2B, 8'hF0, 12'hCF0});
    wr(0, 3'b100, 8'h60);
    chk({oa.enable, ac}, '0);
    rst = 1;
    repeat (2) @(posedge ref_clk) #1;
    rst = 0;
    chk({oa, ob, ac, bc, ah, bl}, '0);
    $display("second channel, disable and reset done");
    summarize();
  end
endmodule : dls_scheduler_tb_top
bind dls_scheduler dls_chk chk_u (.ref_clk(ref_clk), .rst(rst),
  .clk_en(clk_en), .timer2_ovf(timer2_ovf), .timer3_ovf(timer3_ovf),
  .timer4_ovf(timer4_ovf), .wr_a(wr_a),
  .converter_a_control(converter_a_control),
  .converter_a_data_high(converter_a_data_high),
  .converter_a_data_low(converter_a_data_low),
  .converter_a(converter_a));
`default_nettype wire
